// ==== rtl/lcd_drive_cfg.svh ====
// Register offsets, field positions and reset values of the segment panel driver.
// Assumes a 32-bit classic Wishbone bus with byte addresses.
`ifndef LCD_DRIVE_CFG_SVH
`define LCD_DRIVE_CFG_SVH
`define OFS_CTRL_ONE 8'h00
`define OFS_CTRL_TWO 8'h04
`define OFS_CTRL_THREE 8'h08
`define OFS_STATUS 8'h0c
`define OFS_RAM0 8'h10
`define OFS_RAM1 8'h14
`define OFS_RAM2 8'h18
`define OFS_RAM3 8'h1c
`define POS_WAVE 7
`define POS_SUPPLY 6
`define POS_ENABLE 5
`define POS_SHOW 4
`define POS_CMX 2
`define RST_CTRL 8'h00
`define SPLIT_REMOVE_CODE 4'h7
`define FIXED_ONES 2'h3
`endif

// ==== rtl/lcd_drive_pkg.sv ====
// Types shared by the segment panel driver: drive level codes and duty cycles.
// Assumes nothing of its surroundings.
package lcd_drive_pkg;
  // Drive level code per output pin
  typedef enum logic [1:0] {
    lv_vss = 2'h0,
    lv_v3 = 2'h1,
    lv_v2 = 2'h2,
    lv_v1 = 2'h3
  } level_t;
  // Duty cycle selection
  typedef enum logic [1:0] {
    duty_static = 2'h0,
    duty_half = 2'h1,
    duty_third = 2'h2,
    duty_quarter = 2'h3
  } duty_t;
endpackage

// ==== rtl/lcd_drive.sv ====
// Segment panel driver: registers, display RAM, frame timing and drive levels.
// Assumes a classic Wishbone master on clk_i and a subclock arriving on a pin.
`timescale 1ns/1ps
`default_nettype none
`include "lcd_drive_cfg.svh"

// How it works
// - One-third duty frame is three steps, not four.
// - Top bit of control two picks waveform.
// - Control two bits six, five read one.
// - Control two bit four reads zero.
// - Split resistors removed only for code 0111.
// - Duplicate plus static: all commons identical.
// - Duplicate plus half: commons paired.
// - Two-bit field selects four duties.
// - Segment group field enables segment outputs.
// - RAM takes word or byte writes.
// - Levels follow data and alternation.
// - Subclock-only modes stop system-clock frame source.
// - Subclock source keeps running in subclock modes.
// - Standby stops display, supply off.
// - Module standby stops display.
// - Enable cleared halts, supply off, registers kept.
// - Show bit zero blanks data.
// - Frame clock from subclock or divided system clock.
module lcd_drive #(
  parameter int NSEG = 32
) (
  input wire logic clk_i, // System clock
  input wire logic rst_i, // Synchronous reset, active high
  input wire logic wb_cyc_i, // Bus cycle
  input wire logic wb_stb_i, // Bus strobe
  input wire logic wb_we_i, // Write enable
  input wire logic [7:0] wb_adr_i, // Byte address
  input wire logic [3:0] wb_sel_i, // Byte lanes
  input wire logic [31:0] wb_dat_i, // Write data
  output logic [31:0] wb_dat_o, // Read data
  output logic wb_ack_o, // Acknowledge
  input wire logic sub_clk_i, // Subclock from its pin
  input wire logic sub_only_i, // Subclock-only operating mode
  input wire logic standby_i, // Standby mode
  input wire logic module_standby_i, // Module standby
  output logic [7:0] com_level_o, // Common levels, two bits each
  output logic [2*NSEG-1:0] seg_level_o, // Segment levels, two bits each
  output logic alternation_o, // Alternation signal
  output logic drive_supply_on_o, // Internal drive supply connected
  output logic split_removed_o // Split resistors disconnected
);

  typedef struct packed {
    logic ack;
    logic [31:0] rdat;
    logic wave;
    logic [3:0] cds;
    logic supply;
    logic en;
    logic show;
    logic [3:0] fcs;
    lcd_drive_pkg::duty_t duty;
    logic common_duplicate;
    logic [3:0] sgs;
    logic [3:0][31:0] ram;
    logic [7:0] sdiv;
    logic [1:0] subd;
    logic [1:0] step;
    logic m;
    logic s1;
    logic s2;
    logic s3;
    logic [7:0] com;
    logic [2*NSEG-1:0] seg;
    logic pwr;
    logic split;
  } state_t;

  state_t r;
  state_t n;
  logic req;
  logic wr_hit;
  logic [1:0] src;
  logic halt;
  logic tick;
  logic sys_tick;
  logic sub_tick;
  logic [1:0] last;
  logic [1:0] cidx;
  logic [2:0] ncom;
  logic [7:0] mask;
  logic [7:0] rd;

  // Common level for a selected or unselected phase
  function automatic lcd_drive_pkg::level_t com_lvl(input logic sel, input lcd_drive_pkg::duty_t d,
                                                    input logic m);
    if (sel) begin
      com_lvl = m ? lcd_drive_pkg::lv_vss : lcd_drive_pkg::lv_v1;
    end else if (d == lcd_drive_pkg::duty_half) begin
      com_lvl = lcd_drive_pkg::lv_v2;
    end else begin
      com_lvl = m ? lcd_drive_pkg::lv_v2 : lcd_drive_pkg::lv_v3;
    end
  endfunction

  // Segment level for on or off data
  function automatic lcd_drive_pkg::level_t seg_lvl(input logic on, input lcd_drive_pkg::duty_t d,
                                                    input logic m);
    if (on) begin
      seg_lvl = m ? lcd_drive_pkg::lv_v1 : lcd_drive_pkg::lv_vss;
    end else if (d == lcd_drive_pkg::duty_static || d == lcd_drive_pkg::duty_half) begin
      seg_lvl = m ? lcd_drive_pkg::lv_vss : lcd_drive_pkg::lv_v1;
    end else begin
      seg_lvl = m ? lcd_drive_pkg::lv_v3 : lcd_drive_pkg::lv_v2;
    end
  endfunction

  // Frame source, sequencing and drive decode
  always_comb begin
    n = r;
    req = wb_cyc_i & wb_stb_i & ~r.ack;
    // Write lands at the edge where the master samples ack high
    wr_hit = wb_cyc_i & wb_stb_i & wb_we_i & r.ack;
    src = 2'h0;
    halt = ~r.en | standby_i | module_standby_i;
    // Subclock sync and edge
    n.s1 = sub_clk_i;
    n.s2 = r.s1;
    n.s3 = r.s2;
    sub_tick = 1'b0;
    if (r.s2 & ~r.s3) begin
      n.subd = r.subd + 2'h1;
      sub_tick = r.fcs[1] ? (r.subd == 2'h3) : (r.fcs[0] ? r.subd[0] : 1'b1);
    end
    // System clock divider, 2 to 256
    n.sdiv = r.sdiv + 8'h01;
    mask = 8'hff >> (3'h7 - r.fcs[2:0]);
    sys_tick = &(r.sdiv | ~mask);
    tick = ~halt & (r.fcs[3] ? (sys_tick & ~sub_only_i) : sub_tick);
    last = (r.duty == lcd_drive_pkg::duty_third) ? 2'h2 : 2'h3;
    if (tick) begin
      n.step = (r.step == last) ? 2'h0 : r.step + 2'h1;
      if (~r.wave | (r.step == last)) begin
        n.m = ~r.m;
      end
    end
    // Active common index and count per duty
    unique case (r.duty)
      lcd_drive_pkg::duty_static: begin
        cidx = 2'h0;
        ncom = 3'h1;
      end
      lcd_drive_pkg::duty_half: begin
        cidx = {1'b0, r.step[1]};
        ncom = 3'h2;
      end
      lcd_drive_pkg::duty_third: begin
        cidx = r.step;
        ncom = 3'h3;
      end
      lcd_drive_pkg::duty_quarter: begin
        cidx = r.step;
        ncom = 3'h4;
      end
    endcase
    // Common outputs with optional duplication
    for (int j = 0; j < 4; j++) begin
      src = 2'(j);
      if (r.common_duplicate && r.duty == lcd_drive_pkg::duty_static) begin
        src = 2'h0;
      end else if (r.common_duplicate && r.duty == lcd_drive_pkg::duty_half) begin
        src = 2'(j >> 1);
      end
      if ({1'b0, src} < ncom) begin
        n.com[2*j+:2] = com_lvl(src == cidx, r.duty, r.m);
      end else begin
        n.com[2*j+:2] = lcd_drive_pkg::lv_vss;
      end
    end
    // Segment outputs
    for (int i = 0; i < NSEG; i++) begin
      if (5'(i >> 2) < {1'b0, r.sgs}) begin
        n.seg[2*i+:2] = seg_lvl(r.show & r.ram[cidx][i], r.duty, r.m);
      end else begin
        n.seg[2*i+:2] = lcd_drive_pkg::lv_vss;
      end
    end
    if (halt) begin
      n.step = 2'h0;
      n.m = 1'b0;
      n.subd = 2'h0;
      n.com = 8'h00;
      n.seg = '0;
    end
    n.pwr = r.supply & r.en & ~standby_i;
    n.split = (r.cds == `SPLIT_REMOVE_CODE);
    // Register reads
    rd = 8'h00;
    n.rdat = 32'h0;
    unique case (wb_adr_i[7:0] & 8'hfc)
      `OFS_CTRL_ONE: rd = {1'b1, r.supply, r.en, r.show, r.fcs};
      `OFS_CTRL_TWO: rd = {r.wave, `FIXED_ONES, 1'b0, r.cds};
      `OFS_CTRL_THREE: rd = {r.sgs, 1'b0, r.common_duplicate, r.duty};
      `OFS_STATUS: rd = {4'h0, r.step, ~halt, r.m};
      default: rd = 8'h00;
    endcase
    n.rdat = {24'h0, rd};
    if (wb_adr_i >= `OFS_RAM0 && wb_adr_i <= (`OFS_RAM3 | 8'h03)) begin
      n.rdat = r.ram[wb_adr_i[3:2]];
    end
    n.ack = req;
    // Register and RAM writes
    if (wr_hit) begin
      if (wb_sel_i[0]) begin
        unique case (wb_adr_i[7:0] & 8'hfc)
          `OFS_CTRL_ONE: begin
            n.supply = wb_dat_i[`POS_SUPPLY];
            n.en = wb_dat_i[`POS_ENABLE];
            n.show = wb_dat_i[`POS_SHOW];
            n.fcs = wb_dat_i[3:0];
          end
          `OFS_CTRL_TWO: begin
            n.wave = wb_dat_i[`POS_WAVE];
            n.cds = wb_dat_i[3:0];
          end
          `OFS_CTRL_THREE: begin
            n.sgs = wb_dat_i[7:4];
            n.common_duplicate = wb_dat_i[`POS_CMX];
            n.duty = lcd_drive_pkg::duty_t'(wb_dat_i[1:0]);
          end
          default: begin
          end
        endcase
      end
      if (wb_adr_i >= `OFS_RAM0 && wb_adr_i <= (`OFS_RAM3 | 8'h03)) begin
        for (int b = 0; b < 4; b++) begin
          if (wb_sel_i[b]) begin
            n.ram[wb_adr_i[3:2]][8*b+:8] = wb_dat_i[8*b+:8];
          end
        end
      end
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign wb_dat_o = r.rdat;
  assign wb_ack_o = r.ack;
  assign com_level_o = r.com;
  assign seg_level_o = r.seg;
  assign alternation_o = r.m;
  assign drive_supply_on_o = r.pwr;
  assign split_removed_o = r.split;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Fixed bits of control two on read
  property p_fixed_ones;
    req && !wb_we_i && (wb_adr_i & 8'hfc) == `OFS_CTRL_TWO |=> wb_ack_o && wb_dat_o[6:5] == 2'h3;
  endproperty
  a_fixed_ones: assert property (p_fixed_ones) else $error("Reserved bits not one");
  property p_zero_bit;
    req && !wb_we_i && (wb_adr_i & 8'hfc) == `OFS_CTRL_TWO |=> wb_dat_o[4] == 1'b0;
  endproperty
  a_zero_bit: assert property (p_zero_bit) else $error("Bit four not zero");
  // Split resistor decode
  property p_split;
    ##1 split_removed_o == ($past(r.cds) == 4'h7);
  endproperty
  a_split: assert property (p_split) else $error("Split removal wrong");
  // Standby forces supply off
  property p_standby;
    standby_i |=> !drive_supply_on_o && com_level_o == 8'h00;
  endproperty
  a_standby: assert property (p_standby) else $error("Standby left drive on");
  // Display disabled for two cycles running is quiet the next cycle
  property p_disabled;
    !r.en && !$past(r.en) |=> com_level_o == 8'h00 && !alternation_o && !drive_supply_on_o;
  endproperty
  a_disabled: assert property (p_disabled) else $error("Disabled display driving");
  // Duplicated commons in static duty
  property p_dup_static;
    r.common_duplicate && r.duty == lcd_drive_pkg::duty_static |=>
      com_level_o[1:0] == com_level_o[3:2] && com_level_o[1:0] == com_level_o[5:4] &&
      com_level_o[1:0] == com_level_o[7:6];
  endproperty
  a_dup_static: assert property (p_dup_static) else $error("Static commons differ");
  // Paired commons in half duty
  property p_dup_half;
    r.common_duplicate && r.duty == lcd_drive_pkg::duty_half |=>
      com_level_o[1:0] == com_level_o[3:2] && com_level_o[5:4] == com_level_o[7:6];
  endproperty
  a_dup_half: assert property (p_dup_half) else $error("Half commons not paired");
  // Third duty wraps after step two
  property p_third;
    tick && r.duty == lcd_drive_pkg::duty_third && r.step == 2'h2 |=> r.step == 2'h0;
  endproperty
  a_third: assert property (p_third) else $error("Third duty frame length wrong");
  // B waveform alternates only at frame end
  property p_wave_b;
    tick && r.wave && r.step != last |=> $stable(alternation_o) ##1 ($past(halt) || $stable(alternation_o));
  endproperty
  a_wave_b: assert property (p_wave_b) else $error("B waveform toggled mid frame");
  // System-clock source frozen in subclock-only mode
  property p_sub_only;
    sub_only_i && r.fcs[3] && !halt |=> $stable(r.step);
  endproperty
  a_sub_only: assert property (p_sub_only) else $error("Frame ran without system clock");
  // Ack is a single cycle
  property p_ack;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("Ack held too long");

endmodule // lcd_drive
`default_nettype wire

// ==== verif/lcd_panel_model.sv ====
// Panel model: one pixel between common line 0 and segment line 0.
// Assumes level codes of the driver package on both electrodes.
`timescale 1ns/1ps
`default_nettype none
module lcd_panel_model (
  input wire logic [7:0] com_level_i, // All common levels
  input wire logic [1:0] seg_level_i, // Segment 0 level
  output logic signed [2:0] pixel_volt_o // Segment minus common level
);
  // A passive cell sees only the difference between its electrodes
  assign pixel_volt_o = $signed({1'b0, seg_level_i}) - $signed({1'b0, com_level_i[1:0]});
endmodule // lcd_panel_model
`default_nettype wire

// ==== verif/test_lcd_drive.sv ====
// Bench for the segment panel driver: register accesses over Wishbone and panel checks.
// Assumes the driver package and a 200 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module test_lcd_drive;
  logic clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack, sub_clk, sub_only, standby, mod_stby;
  logic alt, supply, split;
  logic [7:0] wb_adr, com;
  logic [3:0] wb_sel;
  logic [31:0] wb_dat_w, wb_dat_r;
  logic [63:0] seg;
  logic signed [2:0] pix;
  int n, err_total, check_count, cyc_cnt;
  logic [7:0] d3[7] = '{8'h03, 8'h03, 8'h02, 8'h01, 8'h03, 8'h03, 8'h03};
  logic [7:0] w2[7] = '{8'h00, 8'h80, 8'h80, 8'h80, 8'h00, 8'h00, 8'h00};
  logic [7:0] fc[7] = '{8'h09, 8'h09, 8'h09, 8'h09, 8'h00, 8'h01, 8'h02};
  int ex[7] = '{4, 16, 12, 16, 8, 16, 32};
  lcd_drive i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat_w), .wb_dat_o(wb_dat_r), .wb_ack_o(wb_ack),
    .sub_clk_i(sub_clk), .sub_only_i(sub_only), .standby_i(standby), .module_standby_i(mod_stby),
    .com_level_o(com), .seg_level_o(seg), .alternation_o(alt), .drive_supply_on_o(supply),
    .split_removed_o(split));
  lcd_panel_model i_panel (.com_level_i(com), .seg_level_i(seg[1:0]), .pixel_volt_o(pix));
  // Clocks: subclock period of eight system cycles, off the system edges
  initial begin
    clk_i = 0;
    forever #2.5 clk_i = ~clk_i;
  end
  initial begin
    sub_clk = 0;
    #1;
    forever #20 sub_clk = ~sub_clk;
  end
  // Hang guard
  always @(posedge clk_i) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 20000) begin
      err_total++;
      conclude();
    end
  end
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One classic cycle, held until ack is sampled high
  task automatic wb_io(input logic we, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
    output logic [31:0] q);
    int k;
    @(posedge clk_i);
    wb_cyc <= 1;
    wb_stb <= 1;
    wb_we <= we;
    wb_adr <= a;
    wb_dat_w <= d;
    wb_sel <= s;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (wb_ack !== 1'b1 && k < 50);
    if (k == 50) check(1, 0);
    q = wb_dat_r;
    wb_cyc <= 0;
    wb_stb <= 0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'h1);
    logic [31:0] q;
    wb_io(1'b1, a, d, s, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb_io(1'b0, a, 32'h0, 4'hf, q);
    check(q, e);
  endtask
  // Wait for an alternation change, then let the outputs settle
  task automatic sync();
    logic a;
    int k;
    @(posedge clk_i);
    a = alt;
    for (k = 0; k < 2000 && alt === a; k++) @(posedge clk_i);
    repeat (3) @(posedge clk_i);
  endtask
  // Cycles between two alternation changes
  task automatic period(output int m);
    sync();
    m = 3;
    for (logic a = alt; m < 2000 && alt === a; m++) @(posedge clk_i);
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    {wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_dat_w, sub_only, standby, mod_stby} = '0;
    {err_total, check_count, cyc_cnt} = '0;
    rst_i = 1;
    repeat (5) @(posedge clk_i);
    rst_i <= 0;
    rd(8'h04, 32'h60);
    wr(8'h04, 32'hff);
    rd(8'h04, 32'hef);
    check(split, 0);
    wr(8'h04, 32'h17);
    rd(8'h04, 32'h67);
    check(split, 1);
    rd(8'h20, 32'h0);
    wr(8'h10, 32'h01);
    wr(8'h10, 32'hffffff00, 4'he);
    rd(8'h10, 32'hffffff01);
    for (int w = 1; w < 4; w++) wr(8'h10 + 8'(4 * w), 32'h01, 4'hf);
    rd(8'h1c, 32'h01);
    wr(8'h08, 32'hf4);
    wr(8'h00, 32'h7f);
    rd(8'h00, 32'hff);
    check(supply, 1);
    sync();
    check(com, {4{alt ? lcd_drive_pkg::lv_vss : lcd_drive_pkg::lv_v1}});
    check(seg[3:0], {com[1:0], ~com[1:0]});
    check(pix, alt ? 3 : -3);
    wr(8'h08, 32'hf5);
    sync();
    check({com[7:6], com[3:2]}, {com[5:4], com[1:0]});
    wr(8'h08, 32'hf3);
    sync();
    check(seg[3:2], alt ? lcd_drive_pkg::lv_v3 : lcd_drive_pkg::lv_v2);
    wr(8'h00, 32'h6f);
    sync();
    check(seg[1:0], alt ? lcd_drive_pkg::lv_v3 : lcd_drive_pkg::lv_v2);
    wr(8'h08, 32'h03);
    sync();
    check(seg, 0);
    // Frame rates for quarter, third and half duty, both waveforms and both clock sources; subclock picked for slow panels
    for (int i = 0; i < 7; i++) begin
      wr(8'h08, d3[i]);
      wr(8'h04, w2[i]);
      wr(8'h00, 8'h70 | fc[i]);
      period(n);
      check(n, ex[i]);
    end
    // Clock source swapped with the frame rate kept the same
    wr(8'h00, 32'h7c);
    period(n);
    check(n, 32);
    wr(8'h00, 32'h72);
    sub_only <= 1;
    period(n);
    check(n, 32);
    wr(8'h00, 32'h79);
    repeat (3) @(posedge clk_i);
    n = alt;
    repeat (100) @(posedge clk_i);
    check(alt, n);
    sub_only <= 0;
    standby <= 1;
    repeat (4) @(posedge clk_i);
    check({alt, supply, com}, 0);
    standby <= 0;
    mod_stby <= 1;
    repeat (4) @(posedge clk_i);
    check({alt, supply, com}, 10'h100);
    mod_stby <= 0;
    wr(8'h00, 32'h50);
    repeat (4) @(posedge clk_i);
    check({supply, com}, 0);
    rd(8'h00, 32'hd0);
    wr(8'h00, 32'h30);
    repeat (4) @(posedge clk_i);
    check(supply, 0);
    conclude();
  end
endmodule // test_lcd_drive
`default_nettype wire
